/* hdl/agtl_params.svh */
// ==========================================================================
// register map, field positions, reset values and timing counts of the
// level-control gain sequencer
// assumes a 40 MHz system clock and 0.75 dB amplifier gain steps
// ==========================================================================
// Functional notes
// - normal attack step 104us at code 0, doubling per code, to 106ms
// - normal decay step 410us at code 0, doubling per code, to 420ms
// - limiter attack step 22.7us at code 0, doubling per code, to 23.2ms
// - limiter decay step 90.8us at code 0, doubling per code, to 93ms
// - ceiling code in control one bits 5:3, resets to 111
// - floor code in control one bits 2:0, resets to 000
// - ceiling 111 means 35.25 dB, 6 dB less per code down to -6.75
// - floor 000 means -12 dB, 6 dB more per code up to 30 dB
// - limits act only while the loop is enabled
// - normal mode never raises gain above the ceiling
// - limiter upper bound is the starting gain, ceiling only if lower
// - gain outside floor-to-ceiling range is pulled back at once
// - hold code in control two bits 7:4, resets to 0000
// - normal mode waits the hold delay before a decay phase
// - hold expiry without interruption starts decay steps
// - signal above target during hold abandons the hold
// - attack interval when reducing, decay interval when raising
// - limiter never raises gain above the gain held at entry
// - near-clip input ramps gain down at fastest attack rate
`ifndef AGTL_PARAMS_SVH
`define AGTL_PARAMS_SVH

// register offsets
`define AGTL_ADDR_CTL1      8'h20
`define AGTL_ADDR_CTL2      8'h21
`define AGTL_ADDR_CTL3      8'h22
`define AGTL_ADDR_STAT      8'h23

// field positions
`define AGTL_EN_BIT         8
`define AGTL_CEIL_LSB       3
`define AGTL_FLOOR_LSB      0
`define AGTL_HOLD_LSB       4
`define AGTL_LVL_LSB        0
`define AGTL_MODE_BIT       8
`define AGTL_DCY_LSB        4
`define AGTL_ATK_LSB        0

// reset values
`define AGTL_EN_RST         1'h0
`define AGTL_CEIL_RST       3'h7
`define AGTL_FLOOR_RST      3'h0
`define AGTL_HOLD_RST       4'h0
`define AGTL_LVL_RST        4'h0
`define AGTL_MODE_RST       1'h0
`define AGTL_DCY_RST        4'h3
`define AGTL_ATK_RST        4'h2

// timing: times in ns as printed, counts derived at the clock rate
`define AGTL_CLK_MHZ        40
`define AGTL_T_ATK_NRM_NS   104000
`define AGTL_T_DCY_NRM_NS   410000
`define AGTL_T_ATK_LIM_NS   22700
`define AGTL_T_DCY_LIM_NS   90800
`define AGTL_T_HOLD_NS      2670000
`define AGTL_CYC(ns)        ((((ns) * `AGTL_CLK_MHZ) + 999) / 1000)
`define AGTL_CODE_MAX       4'hA

`endif

/* hdl/agtl_pkg.sv */
// ==========================================================================
// types shared by the level-control gain sequencer
// assumes agtl_params.svh is on the include path
// ==========================================================================
`include "agtl_params.svh"

package agtl_pkg;

  // loop phase
  typedef enum logic [1:0] {PH_OFF, PH_ATTACK, PH_HOLD, PH_DECAY} agtl_phase_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [8:0] wdata;
    logic       wr;
    logic       rd;
  } agtl_reg_req_t;

  // level detector verdicts
  typedef struct packed {
    logic above;
    logic near_clip;
  } agtl_level_t;

  // software settings
  typedef struct packed {
    logic       en;
    logic       mode;
    logic [2:0] ceil;
    logic [2:0] floor;
    logic [3:0] hold;
    logic [3:0] lvl;
    logic [3:0] atk;
    logic [3:0] dcy;
  } agtl_cfg_t;

  // whole state of the sequencer
  typedef struct packed {
    agtl_cfg_t   cfg;
    agtl_phase_t phase;
    logic [5:0]  gain;
    logic [5:0]  start_gain;
    logic [26:0] timer;
    logic        mode_d;
    logic [8:0]  rdata;
  } agtl_state_t;

endpackage

/* hdl/agtl_core.sv */
// ==========================================================================
// level-control gain sequencer: steps the input amplifier gain
// assumes synchronous level verdicts and a one-cycle register port
// ==========================================================================
`include "agtl_params.svh"

module agtl_core import agtl_pkg::*; #(
  parameter int unsigned ATK_NRM_CYC = `AGTL_CYC(`AGTL_T_ATK_NRM_NS),
  parameter int unsigned DCY_NRM_CYC = `AGTL_CYC(`AGTL_T_DCY_NRM_NS),
  parameter int unsigned HOLD_CYC    = `AGTL_CYC(`AGTL_T_HOLD_NS)
) (
  // clock and reset
  input  logic          clk,
  input  logic          sys_rst,
  // register port
  input  agtl_reg_req_t reg_req,
  output logic [8:0]    reg_rdata,
  // level detector
  input  agtl_level_t   level,
  // amplifier gain
  input  logic [5:0]    manual_gain,
  input  logic          manual_gain_load,
  output logic [5:0]    gain_out
);

  // ========================================================================
  // constants and decoders
  // ========================================================================
  localparam logic [26:0] ATK_LIM_BASE = 27'(`AGTL_CYC(`AGTL_T_ATK_LIM_NS));
  localparam logic [26:0] DCY_LIM_BASE = 27'(`AGTL_CYC(`AGTL_T_DCY_LIM_NS));
  localparam logic [26:0] ATK_NRM_BASE = 27'(ATK_NRM_CYC);
  localparam logic [26:0] DCY_NRM_BASE = 27'(DCY_NRM_CYC);
  localparam logic [26:0] HOLD_BASE    = 27'(HOLD_CYC);

  // codes past the table act as the last entry
  function automatic logic [3:0] sat_code(input logic [3:0] code);
    sat_code = (code > `AGTL_CODE_MAX) ? `AGTL_CODE_MAX : code;
  endfunction

  // one step interval: base doubled per code
  function automatic logic [26:0] step_iv(input logic [26:0] base, input logic [3:0] code);
    step_iv = base << sat_code(code);
  endfunction

  // ceiling code to gain index: 8 steps of 0.75 dB per 6 dB code
  function automatic logic [5:0] ceil_idx(input logic [2:0] code);
    ceil_idx = {code, 3'h7};
  endfunction

  function automatic logic [5:0] floor_idx(input logic [2:0] code);
    floor_idx = {code, 3'h0};
  endfunction

  // ========================================================================
  // derived terms
  // ========================================================================
  agtl_state_t q;
  agtl_state_t d;
  logic [5:0]  hi_w;
  logic [5:0]  lo_w;
  logic        in_rng;
  logic        down;
  logic        mode_chg;
  logic        entry;
  logic [26:0] atk_iv;
  logic [26:0] dcy_iv;
  logic [26:0] hold_iv;
  logic [26:0] tmr_inc;
  logic        tick_atk;
  logic        tick_dcy;
  logic        tick_hold;

  // bounds: limiter caps at the gain held on entry when that is below the ceiling
  assign lo_w     = floor_idx(q.cfg.floor);
  assign hi_w     = (q.cfg.mode && q.start_gain < ceil_idx(q.cfg.ceil)) ? q.start_gain
                                                                        : ceil_idx(q.cfg.ceil);
  assign in_rng   = (q.gain >= lo_w) && (q.gain <= hi_w);
  assign down     = level.above | level.near_clip;
  assign mode_chg = q.cfg.mode != q.mode_d;
  assign entry    = q.cfg.en && (q.phase == PH_OFF || mode_chg);

  // near clip forces the fastest attack of the current mode
  assign atk_iv   = level.near_clip ? (q.cfg.mode ? ATK_LIM_BASE : ATK_NRM_BASE)
                                    : step_iv(q.cfg.mode ? ATK_LIM_BASE : ATK_NRM_BASE, q.cfg.atk);
  assign dcy_iv   = step_iv(q.cfg.mode ? DCY_LIM_BASE : DCY_NRM_BASE, q.cfg.dcy);
  // hold code 1 is the base, so shift by one less
  assign hold_iv  = (q.cfg.hold == 4'h0) ? 27'h0 : (HOLD_BASE << (sat_code(q.cfg.hold) - 4'h1));
  assign tmr_inc  = q.timer + 27'h1;
  assign tick_atk  = tmr_inc >= atk_iv;
  assign tick_dcy  = tmr_inc >= dcy_iv;
  assign tick_hold = tmr_inc >= hold_iv;

  // ========================================================================
  // next state
  // ========================================================================
  always_comb begin
    d        = q;
    d.rdata  = 9'h000;
    d.mode_d = q.cfg.mode;
    // register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `AGTL_ADDR_CTL1: begin
          d.cfg.en    = reg_req.wdata[`AGTL_EN_BIT];
          d.cfg.ceil  = reg_req.wdata[`AGTL_CEIL_LSB +: 3];
          d.cfg.floor = reg_req.wdata[`AGTL_FLOOR_LSB +: 3];
        end
        `AGTL_ADDR_CTL2: begin
          d.cfg.hold = reg_req.wdata[`AGTL_HOLD_LSB +: 4];
          d.cfg.lvl  = reg_req.wdata[`AGTL_LVL_LSB +: 4];
        end
        `AGTL_ADDR_CTL3: begin
          d.cfg.mode = reg_req.wdata[`AGTL_MODE_BIT];
          d.cfg.dcy  = reg_req.wdata[`AGTL_DCY_LSB +: 4];
          d.cfg.atk  = reg_req.wdata[`AGTL_ATK_LSB +: 4];
        end
        default: ; // unmapped and read-only writes are dropped
      endcase
    end
    // register reads, answered next cycle only
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `AGTL_ADDR_CTL1: d.rdata = {q.cfg.en, 2'h0, q.cfg.ceil, q.cfg.floor};
        `AGTL_ADDR_CTL2: d.rdata = {1'h0, q.cfg.hold, q.cfg.lvl};
        `AGTL_ADDR_CTL3: d.rdata = {q.cfg.mode, q.cfg.dcy, q.cfg.atk};
        `AGTL_ADDR_STAT: d.rdata = {1'h0, q.phase, q.gain};
        default:         d.rdata = 9'h000;
      endcase
    end
    // gain sequencing
    if (!q.cfg.en) begin
      // loop off: limits ignored, gain only from the manual path
      d.phase = PH_OFF;
      d.timer = 27'h0;
      if (manual_gain_load) begin
        d.gain = manual_gain;
      end
    end else if (entry) begin
      // start or mode switch: remember the starting gain for the limiter
      d.timer = 27'h0;
      d.phase = q.cfg.mode ? PH_DECAY : PH_HOLD;
      if (q.cfg.mode) begin
        d.start_gain = q.gain;
      end
    end else if (q.gain > hi_w) begin
      // out of range: jump back, no stepping; ceiling checked first, a floor above the ceiling makes the gain alternate between them
      d.gain  = hi_w;
      d.timer = 27'h0;
    end else if (q.gain < lo_w) begin
      d.gain  = lo_w;
      d.timer = 27'h0;
    end else if (down) begin
      // reducing gain always runs on the attack interval
      if (q.phase != PH_ATTACK) begin
        d.phase = PH_ATTACK;
        d.timer = 27'h0;
      end else if (tick_atk) begin
        d.timer = 27'h0;
        if (q.gain > lo_w) begin
          d.gain = q.gain - 6'h1;
        end
      end else begin
        d.timer = tmr_inc;
      end
    end else if (q.phase == PH_ATTACK) begin
      // quiet again: normal mode holds first, limiter goes straight up
      d.phase = q.cfg.mode ? PH_DECAY : PH_HOLD;
      d.timer = 27'h0;
    end else if (q.phase == PH_HOLD) begin
      if (tick_hold) begin
        d.phase = PH_DECAY;
        d.timer = 27'h0;
      end else begin
        d.timer = tmr_inc;
      end
    end else begin
      // raising gain always runs on the decay interval
      if (tick_dcy) begin
        d.timer = 27'h0;
        if (q.gain < hi_w) begin
          d.gain = q.gain + 6'h1;
        end
      end else begin
        d.timer = tmr_inc;
      end
    end
  end

  // ========================================================================
  // state register
  // ========================================================================
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q            <= '0;
      q.cfg.en     <= `AGTL_EN_RST;
      q.cfg.mode   <= `AGTL_MODE_RST;
      q.cfg.ceil   <= `AGTL_CEIL_RST;
      q.cfg.floor  <= `AGTL_FLOOR_RST;
      q.cfg.hold   <= `AGTL_HOLD_RST;
      q.cfg.lvl    <= `AGTL_LVL_RST;
      q.cfg.atk    <= `AGTL_ATK_RST;
      q.cfg.dcy    <= `AGTL_DCY_RST;
      q.phase      <= PH_OFF;
      q.mode_d     <= `AGTL_MODE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign reg_rdata = q.rdata;
  assign gain_out  = q.gain;

  // ========================================================================
  // checks
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // settled gain stays inside the window one cycle after any correction
  AST_GAIN_IN_WINDOW: assert property (
    (q.cfg.en && q.phase != PH_OFF && !mode_chg && lo_w <= hi_w) ##1
      ($stable(q.cfg) && q.phase != PH_OFF) |-> (q.gain <= hi_w && q.gain >= lo_w))
    else $error("gain left the floor-to-ceiling window");

  AST_OFF_MANUAL: assert property (
    (!q.cfg.en && manual_gain_load) |=> (q.gain == $past(manual_gain) && q.phase == PH_OFF))
    else $error("disabled loop did not take the manual gain");

  AST_ONE_STEP: assert property (
    (q.cfg.en && !entry && in_rng && !reg_req.wr) |=>
      (({1'b0, q.gain} <= {1'b0, $past(q.gain)} + 7'h01) && ({1'b0, q.gain} + 7'h01 >= {1'b0, $past(q.gain)})))
    else $error("gain moved more than one step");

  AST_LIMIT_CAP: assert property (
    (q.cfg.en && q.cfg.mode && q.phase != PH_OFF && !mode_chg) ##1
      (q.cfg.mode && !mode_chg && q.phase != PH_OFF) |-> (q.gain <= q.start_gain))
    else $error("limiter raised gain above the starting gain");

  AST_NO_HOLD_LIMIT: assert property (
    (q.cfg.mode && !mode_chg && q.phase != PH_OFF) |-> (q.phase != PH_HOLD))
    else $error("hold phase seen in limiter mode");

  AST_HOLD_ABANDON: assert property (
    (q.cfg.en && !entry && in_rng && q.phase == PH_HOLD && level.above) |=> (q.phase == PH_ATTACK))
    else $error("hold not abandoned on a loud signal");

  AST_HOLD_EXPIRE: assert property (
    (q.cfg.en && !entry && in_rng && q.phase == PH_HOLD && !down && tick_hold) |=>
      (q.phase == PH_DECAY && q.timer == 27'h0))
    else $error("hold expiry did not start decay");

  AST_ATTACK_STEP: assert property (
    (q.cfg.en && !entry && in_rng && down && q.phase == PH_ATTACK && tick_atk && q.gain > lo_w) |=>
      (q.gain == $past(q.gain) - 6'h1))
    else $error("attack interval elapsed without one step down");

  AST_DECAY_STEP: assert property (
    (q.cfg.en && !entry && in_rng && !down && q.phase == PH_DECAY && tick_dcy && q.gain < hi_w) |=>
      (q.gain == $past(q.gain) + 6'h1))
    else $error("decay interval elapsed without one step up");

  AST_READ_STAT: assert property (
    (reg_req.rd && reg_req.addr == `AGTL_ADDR_STAT) |=> (reg_rdata == {1'h0, $past(q.phase), $past(q.gain)}))
    else $error("status read returned wrong data");

  // main scenarios
  COV_HOLD_TO_DECAY: cover property (q.phase == PH_HOLD ##1 q.phase == PH_DECAY);
  COV_LIMIT_ATTACK:  cover property (q.cfg.mode && q.phase == PH_ATTACK && tick_atk);
  COV_CLAMP:         cover property (q.cfg.en && !entry && q.gain > hi_w);
  COV_CLIP_RAMP:     cover property (level.near_clip && q.phase == PH_ATTACK && tick_atk);

endmodule

/* test/agtl_level_model.sv */
// ==========================================================================
// level detector model beside the input amplifier
// assumes a gain index from the sequencer and a bench-set loudness
// ==========================================================================
module agtl_level_model import agtl_pkg::*; (
  // clock
  input  logic        clk,
  // amplifier side
  input  logic [5:0]  gain,
  input  logic [6:0]  loud,
  // verdicts
  output agtl_level_t level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sum;

  // loudness after the amplifier
  assign sum = {2'h0, gain} + {1'h0, loud};

  // one cycle of detector lag, like a real peak follower
  initial level = '0;
  always @(posedge clk) begin
    level.above     <= sum > 8'h40;
    level.near_clip <= sum > 8'h64;
  end
endmodule

/* test/test_agtl_core.sv */
// ==========================================================================
// self-checking bench of the level-control gain sequencer
// assumes shortened normal attack, decay and hold counts, full limiter counts, and the level detector model
// ==========================================================================
`include "agtl_params.svh"

module test_agtl_core import agtl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ATK = 8;
  localparam int DCY = 16;
  localparam int HLD = 20;
  // design ports
  logic          clk;
  logic          sys_rst;
  agtl_reg_req_t reg_req;
  logic [8:0]    reg_rdata;
  agtl_level_t   level;
  logic [5:0]    manual_gain;
  logic          manual_gain_load;
  logic [5:0]    gain_out;
  logic [6:0]    loud;
  int            n_errors = 0;
  int            n_compared = 0;
  int            cycles = 0;

  agtl_core #(.ATK_NRM_CYC(ATK), .DCY_NRM_CYC(DCY), .HOLD_CYC(HLD)) dut (
    .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .level(level), .manual_gain(manual_gain),
    .manual_gain_load(manual_gain_load), .gain_out(gain_out));

  agtl_level_model partner (.clk(clk), .gain(gain_out), .loud(loud), .level(level));

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, about twice the longest run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // register port: one-cycle strobes, a gap edge between calls
  task automatic wr(input logic [7:0] a, input logic [8:0] d);
    @(posedge clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge clk);
    reg_req.wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge clk);
    reg_req.rd   <= 1'b0;
    #1;
    chk("read data", {3'h0, exp}, {3'h0, reg_rdata});
  endtask

  task automatic load(input logic [5:0] g);
    @(posedge clk);
    manual_gain      <= g;
    manual_gain_load <= 1'b1;
    @(posedge clk);
    manual_gain_load <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_loud(input logic [6:0] v);
    @(posedge clk);
    loud <= v;
  endtask

  // next gain change; iv 0 only resynchronises to the step grid
  task automatic step(input logic [5:0] dlt, input int iv, input int lim);
    logic [5:0] g0;
    int         n;
    g0 = gain_out;
    n  = 0;
    while (gain_out === g0 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("gain step", {6'h0, 6'(g0 + dlt)}, {6'h0, gain_out});
    if (iv > 0) chk("step interval", iv[11:0], n[11:0]);
  endtask

  initial begin
    sys_rst          = 1'b1;
    reg_req          = '0;
    manual_gain      = 6'h00;
    manual_gain_load = 1'b0;
    loud             = 7'h00;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, read-only status, unmapped place
    rd(`AGTL_ADDR_CTL1, 9'h038);
    rd(`AGTL_ADDR_CTL2, 9'h000);
    rd(`AGTL_ADDR_CTL3, 9'h032);
    wr(`AGTL_ADDR_STAT, 9'h1FF);
    rd(`AGTL_ADDR_STAT, 9'h000);
    rd(8'h24, 9'h000);
    wr(`AGTL_ADDR_CTL2, 9'h0A5);
    rd(`AGTL_ADDR_CTL2, 9'h0A5);
    // ceiling codes 0 to 6 pull a parked high gain down at entry, code 7 leaves it at 3F
    for (int c = 0; c < 8; c++) begin
      wr(`AGTL_ADDR_CTL1, 9'(c * 8));
      load(6'h3F);
      cyc(3);
      chk("gain while disabled", 12'h03F, {6'h0, gain_out});
      wr(`AGTL_ADDR_CTL1, 9'(256 + c * 8));
      cyc(3);
      chk("ceiling clamp", 12'(c * 8 + 7), {6'h0, gain_out});
    end
    // floor codes 1 to 7 lift a low gain at entry, code 0 leaves it at 00
    for (int c = 0; c < 8; c++) begin
      wr(`AGTL_ADDR_CTL1, 9'(56 + c));
      load(6'h00);
      wr(`AGTL_ADDR_CTL1, 9'(312 + c));
      cyc(3);
      chk("floor clamp", 12'(c * 8), {6'h0, gain_out});
    end
    // hold, then decay up to a low ceiling
    wr(`AGTL_ADDR_CTL1, 9'h010);
    wr(`AGTL_ADDR_CTL2, 9'h010);
    wr(`AGTL_ADDR_CTL3, 9'h010);
    load(6'h14);
    wr(`AGTL_ADDR_CTL1, 9'h110);
    cyc(12);
    rd(`AGTL_ADDR_STAT, 9'h094);
    step(6'h01, 0, 100);
    step(6'h01, 2 * DCY, 100);
    step(6'h01, 2 * DCY, 100);
    cyc(150);
    chk("gain at ceiling", 12'h017, {6'h0, gain_out});
    // attack, then a hold broken by a loud signal
    set_loud(7'h32);
    step(6'h3F, 0, 50);
    step(6'h3F, ATK, 50);
    set_loud(7'h00);
    cyc(4);
    rd(`AGTL_ADDR_STAT, 9'h095);
    set_loud(7'h32);
    cyc(3);
    rd(`AGTL_ADDR_STAT, 9'h055);
    // near clipping beats a clamped slow attack code
    wr(`AGTL_ADDR_CTL3, 9'h01F);
    rd(`AGTL_ADDR_CTL3, 9'h01F);
    set_loud(7'h5A);
    step(6'h3F, 0, 50);
    step(6'h3F, ATK, 50);
    // limiter never climbs above its starting gain
    set_loud(7'h00);
    wr(`AGTL_ADDR_CTL1, 9'h038);
    wr(`AGTL_ADDR_CTL3, 9'h100);
    load(6'h1E);
    wr(`AGTL_ADDR_CTL1, 9'h138);
    cyc(4000);
    chk("limiter start gain", 12'h01E, {6'h0, gain_out});
    set_loud(7'h28);
    step(6'h3F, 0, 1000);
    step(6'h3F, 908, 1000);
    set_loud(7'h00);
    step(6'h01, 0, 4000);
    step(6'h01, 3632, 4000);
    cyc(4000);
    chk("limiter top gain", 12'h01E, {6'h0, gain_out});
    report_and_stop();
  end
endmodule
